// [inc/tpmc_pkg.sv]
/*
  Shared constants of the transceiver power mode controller: timing,
  register offsets, field positions, reset values, commands and states.
  Assumes a 200 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package tpmc_pkg;

  // Clock period and derived cycle counts.
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SLEEP_HOLD_NS = 50000;
  localparam int unsigned SLEEP_HOLD_CYC = (SLEEP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // Control fields and reset value.
  localparam int unsigned CTRL_AUTO_WAKE = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status fields.
  localparam int unsigned ST_STATE_LO = 0;
  localparam int unsigned ST_ERR = 2;
  localparam int unsigned ST_RXD = 3;
  localparam int unsigned ST_REG_ON = 4;
  localparam int unsigned ST_WAKE = 5;
  localparam int unsigned ST_POR = 6;
  localparam int unsigned ST_BUSY = 7;

  // Mode commands written to the command register.
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_NORMAL = 2'h1;
  localparam logic [1:0] CMD_POS = 2'h2;
  localparam logic [1:0] CMD_SLEEP = 2'h3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Controller states.
  typedef enum logic [1:0] {
    S_POS,
    S_NORMAL,
    S_GOTO,
    S_SLEEP
  } tpmc_state_t;

endpackage

// [rtl/tpmc_axil_slave.sv]
/*
  AXI4-Lite slave front end: takes address and data in either order,
  issues one write strobe, and answers reads one cycle after the address.
  Assumes the owner decodes addresses combinationally.
*/
`timescale 1ns/1ps
module tpmc_axil_slave #(
  parameter int unsigned AW = 8
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  output logic awready,
  input logic [AW-1:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [AW-1:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input logic wr_ok,
  output logic [AW-1:0] rd_addr,
  input logic [31:0] rd_data,
  input logic rd_ok
);
  import tpmc_pkg::*;

  logic aw_held;
  logic w_held;

  // Each channel is refused while its word waits or a response is open.
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_held && w_held && !bvalid;
  assign rd_addr = araddr;

  // Address and data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_en) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (wr_en) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read response; data are registered when the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0000_0000;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// [rtl/tpmc_host.sv]
/*
  Host-side power mode controller for a fault-tolerant low-speed CAN
  transceiver. It drives the active-low standby control and enable pins,
  watches the fault/flag, receive and regulator turn-on pins, and reports
  to software over AXI4-Lite. Assumes the transceiver pins are synchronous
  to aclk and that the fault/flag and receive indications are active low.
*/
// The register addresses and the AXI4-Lite register port are this design's own decisions.
// What the document requires
// [R1] Pin pairs select normal, standby, goto-sleep, sleep.
// [R2] Device floats regulator output in sleep.
// [R3] Device switches low-line bias by mode.
// [R4] Standby equals sleep with regulator output high.
// [R5] Device routes flags to fault and receive pins.
// [R6] Device clears wake interrupt entering normal.
// [R7] Device clears power-on flag entering normal.
// [R8] Device filters local edge wake-ups.
// [R9] Remote wake needs long dominant frame phase.
// [R10] Device raises regulator output on wake-up.
// [R11] Only four events restore the regulator output.
// [R12] Host holds goto-sleep for the hold time.
// [R13] Sleep follows only a goto-sleep command.
// [R14] Device forces mode pins low on supply loss.
// [R15] Device flags battery power-on at first supply.
// [R16] Over-temperature disables only the transmitter.
// [R17] Low power modes keep partial failure detection.
// [R18] Host reads wake indication, then selects normal.
// [R19] Normal mode receive pin carries bus data.
// [R20] Normal mode fault pin shows wiring failures.
// [R21] Device synchronises pins, counts filter cycles.
// [R22] Sleep ignores mode pins until woken.
`timescale 1ns/1ps
module tpmc_host #(
  parameter int unsigned HOLD_CYC = tpmc_pkg::SLEEP_HOLD_CYC
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  output logic awready,
  input logic [tpmc_pkg::ADDR_W-1:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [tpmc_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic stb_n,
  output logic en,
  input logic err_n,
  input logic rxd,
  input logic regulator_turn_on_out
);
  import tpmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the hold and settle counts must fit the timer.
  if (HOLD_CYC < 1 || HOLD_CYC >= (1 << TMR_W)) begin : g_bad_hold
    $error("HOLD_CYC does not fit the timer");
  end
  if (SETTLE_CYC >= (1 << TMR_W)) begin : g_bad_settle
    $error("SETTLE_CYC does not fit the timer");
  end

  // Decode of the mapped register offsets, shared by reads and writes.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_CMD) || (a == REG_STATUS);
  endfunction

  // Target state of an accepted mode command.
  function automatic tpmc_state_t cmd_state(input logic [1:0] c);
    if (c == CMD_NORMAL) begin
      return S_NORMAL;
    end else if (c == CMD_POS) begin
      return S_POS;
    end else begin
      return S_GOTO;
    end
  endfunction

  tpmc_state_t state;
  tpmc_state_t next_state;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic auto_wake;
  logic wake_seen;
  logic por_seen;
  logic settled;
  logic busy;
  logic cmd_go;
  logic [1:0] cmd;
  logic wake_evt;
  logic wake_clr;
  logic por_clr;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic [TMR_W-1:0] goto_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus front end.
  tpmc_axil_slave #(
    .AW(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  assign wr_ok = is_mapped(wr_addr);
  assign rd_ok = is_mapped(rd_addr);

  // Read multiplexer; the command register reads back as zero.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == REG_CTRL) begin
      rd_data[CTRL_AUTO_WAKE] = auto_wake;
    end else if (rd_addr == REG_STATUS) begin
      rd_data[ST_STATE_LO +: 2] = state;
      rd_data[ST_ERR] = err_n;
      rd_data[ST_RXD] = rxd;
      rd_data[ST_REG_ON] = regulator_turn_on_out;
      rd_data[ST_WAKE] = wake_seen;
      rd_data[ST_POR] = por_seen;
      rd_data[ST_BUSY] = busy;
    end
  end

  // Control register: automatic return to normal on a wake-up from sleep.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_wake <= CTRL_RESET[CTRL_AUTO_WAKE];
    end else if (wr_en && wr_addr == REG_CTRL && wr_strb[0]) begin
      auto_wake <= wr_data[CTRL_AUTO_WAKE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode commands. A command during a hold or settle wait is dropped,
  // which keeps the goto-sleep pair from being cut short.
  assign busy = (state == S_GOTO) || !settled;
  assign cmd = wr_data[1:0];
  assign cmd_go = wr_en && wr_addr == REG_CMD && wr_strb[0] && !busy && cmd != CMD_NONE;

  // Wake indications are only trusted once the pins have settled.
  always_comb begin
    wake_evt = 1'b0;
    if (settled && state == S_SLEEP) begin
      wake_evt = !rxd || !err_n; // R9 R18
    end else if (settled && state == S_POS) begin
      wake_evt = !rxd; // R18
    end
  end

  // Next state.
  always_comb begin
    next_state = state;
    case (state)
      S_POS, S_NORMAL: begin
        if (cmd_go) begin
          next_state = cmd_state(cmd); // R1
        end
      end
      S_GOTO: begin
        if (settled) begin
          next_state = S_SLEEP; // R12
        end
      end
      S_SLEEP: begin
        if (wake_evt && auto_wake) begin
          next_state = S_NORMAL; // R18
        end else if (cmd_go && cmd != CMD_SLEEP) begin
          next_state = cmd_state(cmd);
        end
      end
      default: begin
        next_state = S_POS;
      end
    endcase
  end

  // State register; reset starts in power-on standby to read the flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_POS;
    end else begin
      state <= next_state;
    end
  end

  // Mode pins follow the next state so they change with the state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stb_n <= 1'b1;
      en <= 1'b0;
    end else begin
      stb_n <= (next_state == S_POS) || (next_state == S_NORMAL); // R1
      en <= (next_state == S_NORMAL) || (next_state == S_GOTO); // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One timer serves both waits: the goto-sleep hold and the settle time
  // after any other mode change.
  assign tmr_load = (next_state != state);
  assign tmr_val = (next_state == S_GOTO) ? TMR_W'(HOLD_CYC) : TMR_W'(SETTLE_CYC); // R12

  tpmc_timer #(
    .WIDTH(TMR_W),
    .RESET_VAL(TMR_W'(SETTLE_CYC))
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(settled)
  );

  // Sticky indications; a new event wins over a clear in the same cycle.
  assign wake_clr = wr_en && wr_addr == REG_STATUS && wr_strb[0] && wr_data[ST_WAKE];
  assign por_clr = wr_en && wr_addr == REG_STATUS && wr_strb[0] && wr_data[ST_POR];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_seen <= 1'b0;
    end else if (wake_evt) begin
      wake_seen <= 1'b1; // R18
    end else if (wake_clr) begin
      wake_seen <= 1'b0;
    end
  end

  // The power-on flag shows on the fault pin only in power-on standby.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_seen <= 1'b0;
    end else if (state == S_POS && settled && !err_n) begin
      por_seen <= 1'b1;
    end else if (por_clr) begin
      por_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking helper: cycles for which the goto-sleep pair has stood.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      goto_cnt <= '0;
    end else if (stb_n || !en) begin
      goto_cnt <= '0;
    end else if (goto_cnt != '1) begin
      goto_cnt <= goto_cnt + 1'b1;
    end
  end

  chk_goto_hold_time: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    (!stb_n && $fell(en)) |-> (goto_cnt >= HOLD_CYC))
    else $error("goto-sleep pair released before the hold time");

  chk_sleep_via_goto: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    (!stb_n && !en && $changed(en)) |-> $past(!stb_n))
    else $error("sleep pair entered without goto-sleep");

  chk_normal_cmd_pins: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    (cmd_go && cmd == CMD_NORMAL) |=> (stb_n && en) ##1 (stb_n && en))
    else $error("normal command did not drive both pins high");

  chk_wake_to_normal: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    (wake_evt && auto_wake && state == S_SLEEP) |=> (stb_n && en && wake_seen))
    else $error("wake-up did not return the device to normal");

  chk_wake_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    wake_evt |=> wake_seen)
    else $error("wake indication was lost");

endmodule

// [rtl/tpmc_timer.sv]
/*
  Down counter used for the goto-sleep hold and pin settle waits.
  Assumes load is a one-cycle pulse from the owning state machine.
*/
`timescale 1ns/1ps
module tpmc_timer #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input logic aclk,
  input logic aresetn,
  input logic load,
  input logic [WIDTH-1:0] load_val,
  output logic done
);

  logic [WIDTH-1:0] count;

  // Reload on request, else count down and rest at zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= RESET_VAL;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);

endmodule

// [tb/tb_tpmc_host.sv]
/*
  Self-checking bench of the host power mode controller against a transceiver model.
  Assumes HOLD_CYC of 20 and the package settle count.
*/
`timescale 1ns/1ps
module tb_tpmc_host;
  import tpmc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, stb_n, en, err_n, rxd, reg_on, bias;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, st;
  logic wake_req = 1'h0, bus_dom = 1'h0, line_fault = 1'h0, local_pin = 1'h1, logic_low = 1'h0;
  int fail_count = 0, tests_run = 0, cyc = 0;

  always #2.5 aclk = ~aclk;

  tpmc_host #(.HOLD_CYC(20)) DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .stb_n(stb_n), .en(en), .err_n(err_n), .rxd(rxd),
    .regulator_turn_on_out(reg_on));
  tpmc_xcvr_model #(.HOLD(20), .WAKE_CYC(8), .LOCAL_CYC(6)) xcvr (.aclk(aclk), .stb_n(stb_n), .en(en),
    .wake_req(wake_req), .local_pin(local_pin), .logic_low(logic_low), .bus_dom(bus_dom), .line_fault(line_fault),
    .err_n(err_n), .rxd(rxd), .regulator_turn_on_out(reg_on), .low_line_bias_pin(bias));

  ////////////////////////////////////////////////////////////
  // Shared verdict, compare and bus tasks.
  task automatic report_and_stop;
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bready stays high, so the response is taken at the edge it is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    chk(bresp, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    st = rdata;
    rr = rresp;
  endtask

  // Polling is bounded; a stuck busy bit shows up in the next compare.
  task automatic wait_idle;
    for (int i = 0; i < 200; i++) begin
      rd(REG_STATUS);
      if (st[ST_BUSY] === 1'h0) break;
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_power_on;
    chk({stb_n, en}, 2'h2);
    wait_idle();
    chk(st, 32'h58);
    rd(REG_CTRL);
    chk(st, CTRL_RESET);
    rd(8'h0C);
    chk(st, 32'h0);
    chk(rr, RESP_SLVERR);
  endtask

  // A sleep command right behind the normal command must be dropped.
  task automatic t_normal;
    wr(REG_CMD, 32'h1);
    chk({stb_n, en}, 2'h3);
    chk(bias, 1'h1);
    wr(REG_CMD, 32'h3);
    rd(REG_STATUS);
    chk(st, 32'hDD);
    chk({stb_n, en}, 2'h3);
    wait_idle();
    wr(REG_STATUS, 32'h40);
    rd(REG_STATUS);
    chk(st, 32'h1D);
    bus_dom <= 1'h1;
    line_fault <= 1'h1;
    repeat (3) @(posedge aclk);
    rd(REG_STATUS);
    chk(st, 32'h11);
    bus_dom <= 1'h0;
    line_fault <= 1'h0;
  endtask

  // A short dominant burst must not wake; a long one must.
  task automatic t_sleep_wake;
    wr(REG_CMD, 32'h3);
    chk({stb_n, en}, 2'h1);
    wait_idle();
    chk({stb_n, en}, 2'h0);
    chk(bias, 1'h0);
    chk(st, 32'h0F);
    wake_req <= 1'h1;
    line_fault <= 1'h1;
    repeat (6) @(posedge aclk);
    wake_req <= 1'h0;
    repeat (3) @(posedge aclk);
    rd(REG_STATUS);
    chk(st, 32'h0F);
    line_fault <= 1'h0;
    wake_req <= 1'h1;
    repeat (12) @(posedge aclk);
    wake_req <= 1'h0;
    repeat (20) @(posedge aclk);
    wait_idle();
    chk(st, 32'h3D);
    chk({stb_n, en}, 2'h3);
  endtask

  // Manual wake: a filtered local edge, then power-on standby, normal and a logic supply dip.
  task automatic t_local_manual;
    wr(REG_CTRL, 32'h0);
    wr(REG_STATUS, 32'h20);
    wr(REG_CMD, 32'h3);
    wait_idle();
    chk(st, 32'h0F);
    local_pin <= 1'h0;
    repeat (2) @(posedge aclk);
    rd(REG_STATUS);
    chk(st, 32'h0F);
    repeat (8) @(posedge aclk);
    rd(REG_STATUS);
    chk(st, 32'h33);
    chk({stb_n, en}, 2'h0);
    wr(REG_CMD, 32'h2);
    chk({stb_n, en}, 2'h2);
    wait_idle();
    chk(st, 32'h34);
    chk(bias, 1'h0);
    wr(REG_CMD, 32'h1);
    chk({stb_n, en}, 2'h3);
    wait_idle();
    logic_low <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({bias, reg_on}, 2'h1);
    logic_low <= 1'h0;
    repeat (2) @(posedge aclk);
    chk(bias, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence and hang guard.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_power_on();
    t_normal();
    t_sleep_wake();
    t_local_manual();
    report_and_stop();
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
endmodule

// [tb/tpmc_xcvr_model.sv]
/*
  Behavioural model of the transceiver mode pins, wake flags and regulator pin.
  Assumes pins are sampled on aclk and the regulator line has a pull-down.
*/
`timescale 1ns/1ps
module tpmc_xcvr_model #(
  parameter int unsigned HOLD = 20,
  parameter int unsigned WAKE_CYC = 8,
  parameter int unsigned LOCAL_CYC = 6
) (
  input wire logic aclk,
  input wire logic stb_n,
  input wire logic en,
  input wire logic wake_req,
  input wire logic local_pin,
  input wire logic logic_low,
  input wire logic bus_dom,
  input wire logic line_fault,
  output logic err_n,
  output logic rxd,
  output logic regulator_turn_on_out,
  output logic low_line_bias_pin
);
  ////////////////////////////////////////////////////////////
  // The power-on flag starts set as after a cold battery start.
  logic por_flag = 1'h1;
  logic wake_flag = 1'h0;
  logic reg_on = 1'h1;
  logic armed = 1'h0;
  logic prev_stb_n = 1'h1;
  logic prev_local = 1'h1;
  int hold_cnt = 0;
  int wake_cnt = 0;
  int local_cnt = 0;
  // A logic supply under its fail-safe threshold reads as both mode pins low.
  wire stb_i = stb_n & !logic_low;
  wire en_i = en & !logic_low;
  wire normal = stb_i & en_i;
  wire goto_cmd = !stb_i & en_i;
  // Remote wake needs a long dominant phase; local wake a level that outlasts the filter.
  wire remote_hit = !normal && wake_req && (wake_cnt + 1 == WAKE_CYC);
  wire local_hit = !normal && (local_pin == prev_local) && (local_cnt == LOCAL_CYC);

  // Mode and wake tracking on aclk, every filter time a cycle count; only a fully
  // held goto-sleep may float the regulator.
  always @(posedge aclk) begin
    prev_stb_n <= stb_i;
    prev_local <= local_pin;
    hold_cnt <= goto_cmd ? hold_cnt + 1 : 0;
    if (goto_cmd && hold_cnt + 1 >= HOLD) armed <= 1'h1;
    if (!stb_i && !en_i && armed) reg_on <= 1'h0;
    wake_cnt <= (!normal && wake_req) ? wake_cnt + 1 : 0;
    if (local_pin != prev_local) local_cnt <= 1;
    else if (local_cnt != 0) local_cnt <= (local_cnt == LOCAL_CYC) ? 0 : local_cnt + 1;
    if (remote_hit || local_hit) begin
      wake_flag <= 1'h1;
      reg_on <= 1'h1;
      armed <= 1'h0;
    end
    // Sleep ignores the pins until a wake or a rising standby control line.
    if (stb_i && !prev_stb_n) begin
      reg_on <= 1'h1;
      armed <= 1'h0;
    end
    if (normal) begin
      wake_flag <= 1'h0;
      por_flag <= 1'h0;
      armed <= 1'h0;
    end
  end

  // Output routing by mode; a floated regulator line reads low through its pull-down.
  // Over-temperature only silences the transmitter, which is left out, so routing never sees it.
  // Partial failure detection in low power never reaches the flag pins.
  always_comb begin
    low_line_bias_pin = normal;
    if (normal) begin
      rxd = !bus_dom;
      err_n = !line_fault;
    end else if (stb_i) begin
      rxd = !wake_flag;
      err_n = !por_flag;
    end else begin
      rxd = !wake_flag;
      err_n = !wake_flag;
    end
  end
  assign regulator_turn_on_out = reg_on;
endmodule
